// File: area_bus_width_idle_config.sv
`default_nettype none

module area_bus_width_idle_config (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic MANUAL_RESET_I,
  input wire logic STANDBY_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [area_cfg_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [area_cfg_pkg::DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [area_cfg_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [area_cfg_pkg::DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  input wire area_cfg_pkg::bus_req_s BUS_REQ_I,
  output logic BUS_GRANT_O,
  output logic IDLE_GAP_ACTIVE_O,
  output logic [11:0] AREA_WIDTH_CODE_O,
  output logic [5:0] AREA_WIDTH_RESERVED_O,
  output logic UPPER_LANE_GPIO_SELECT_O,
  input wire logic [area_cfg_pkg::PORT_W-1:0] BUS_UPPER_DATA_I,
  input wire logic BUS_UPPER_DRIVE_I,
  output logic [area_cfg_pkg::PORT_W-1:0] BUS_UPPER_DATA_O,
  input wire logic [area_cfg_pkg::PORT_W-1:0] UPPER_DATA_LANE_PINS_I,
  output logic [area_cfg_pkg::PORT_W-1:0] UPPER_DATA_LANE_PINS_O,
  output logic [area_cfg_pkg::PORT_W-1:0] UPPER_DATA_LANE_PINS_OE_N_O,
  input wire logic HOLD_I,
  output logic HOLD_SAMPLED_O,
  output logic HOLD_INPUT_EDGE_SELECT_O
);
  import area_cfg_pkg::*;

  typedef struct packed {
    logic [15:0] area_bus_width_config;
    logic [15:0] area_idle_cycle_config;
    logic hold_input_edge_select;
    logic [PORT_W-1:0] port_data;
    logic [PORT_W-1:0] port_dir;
    logic [PORT_W-1:0] pins_out;
    logic [PORT_W-1:0] pins_oe_n;
    logic [PORT_W-1:0] bus_upper;
    logic [PORT_W-1:0] pins_seen;
    logic hold_meta;
    logic hold_sync;
    logic hold_direct;
    logic hold_out;
  } cfg_s;

  cfg_s s_reg;
  cfg_s s_next;

  reg_wr_s wr;
  reg_rd_s rd;
  reg_rsp_s rd_rsp;
  logic wr_ok;
  logic gap_active;
  logic gap_grant;
  logic [5:0] width_rsvd;
  logic lane_conflict;
  logic [15:0] status_word;
  logic [15:0] width_word;

  // Protection attributes carry no meaning for these registers
  logic unused_prot;
  assign unused_prot = ^{S_AXI_AWPROT_I, S_AXI_ARPROT_I};

  axi_lite_reg_port u_port (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .awaddr_i(S_AXI_AWADDR_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .bresp_o(S_AXI_BRESP_O),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .araddr_i(S_AXI_ARADDR_I),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .wr_o(wr),
    .wr_ok_i(wr_ok),
    .rd_o(rd),
    .rd_rsp_i(rd_rsp)
  );

  // Bus sequencing restarts on a manual reset, the configuration does not
  idle_gap_ctrl u_gap (
    .clk_i(CLK_I),
    .reset_i(RESET_I || MANUAL_RESET_I),
    .hold_i(STANDBY_I),
    .idle_cfg_i(s_reg.area_idle_cycle_config),
    .req_i(BUS_REQ_I),
    .ready_o(gap_grant),
    .gap_active_o(gap_active)
  );

  // Width codes per area; 11 is not legal while the upper lane is a port
  always_comb begin
    width_rsvd = '0;
    lane_conflict = 1'b0;
    for (int n = FIRST_WIDTH_AREA; n <= LAST_WIDTH_AREA; n++) begin
      logic [1:0] code;
      code = area_field(s_reg.area_bus_width_config, 3'(n));
      if (code == WIDTH_RSVD) begin
        width_rsvd[n-1] = 1'b1;
      end
      if (code == WIDTH_32 && s_reg.area_bus_width_config[GPIO_SEL_BIT]) begin
        width_rsvd[n-1] = 1'b1;
        lane_conflict = 1'b1;
      end
    end
  end

  assign width_word = s_reg.area_bus_width_config & WIDTH_CFG_KEEP;

  always_comb begin
    status_word = '0;
    status_word[5:0] = width_rsvd;
    status_word[STAT_CONFLICT_BIT] = lane_conflict;
    status_word[STAT_GAP_BIT] = gap_active;
    status_word[STAT_EDGE_BIT] = s_reg.hold_input_edge_select;
  end

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_WIDTH_CFG || a == OFS_IDLE_CFG || a == OFS_PORT_DATA ||
           a == OFS_PORT_DIR || a == OFS_STATUS;
  endfunction

  assign wr_ok = mapped(wr.addr);

  always_comb begin
    rd_rsp = '0;
    rd_rsp.ok = mapped(rd.addr);
    unique case (rd.addr)
      OFS_WIDTH_CFG: rd_rsp.data = {16'h0000, width_word};
      // The edge select reads back only in the status word and bit 14 is reserved
      OFS_IDLE_CFG: rd_rsp.data = {16'h0000, s_reg.area_idle_cycle_config & IDLE_CFG_KEEP};
      OFS_PORT_DATA: rd_rsp.data = {24'h000000, s_reg.pins_seen};
      OFS_PORT_DIR: rd_rsp.data = {24'h000000, s_reg.port_dir};
      OFS_STATUS: rd_rsp.data = {16'h0000, status_word};
      default: rd_rsp.data = '0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    if (wr.en) begin
      unique case (wr.addr)
        OFS_WIDTH_CFG: begin
          s_next.area_bus_width_config =
            merge16(s_reg.area_bus_width_config, wr.data, wr.strb) & WIDTH_CFG_KEEP;
        end
        OFS_IDLE_CFG: begin
          s_next.area_idle_cycle_config =
            merge16(s_reg.area_idle_cycle_config, wr.data, wr.strb) & IDLE_CFG_KEEP;
          if (wr.strb[1]) begin
            s_next.hold_input_edge_select = wr.data[EDGE_SEL_BIT];
          end
        end
        OFS_PORT_DATA: begin
          if (wr.strb[0]) begin
            s_next.port_data = wr.data[PORT_W-1:0];
          end
        end
        OFS_PORT_DIR: begin
          if (wr.strb[0]) begin
            s_next.port_dir = wr.data[PORT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Upper lane belongs either to the bus or to the port, never both
    if (s_reg.area_bus_width_config[GPIO_SEL_BIT]) begin
      s_next.pins_out = s_reg.port_data;
      s_next.pins_oe_n = ~s_reg.port_dir;
      s_next.bus_upper = '0;
    end else begin
      s_next.pins_out = BUS_UPPER_DATA_I;
      s_next.pins_oe_n = {PORT_W{!BUS_UPPER_DRIVE_I}};
      s_next.bus_upper = UPPER_DATA_LANE_PINS_I;
    end
    s_next.pins_seen = UPPER_DATA_LANE_PINS_I;

    // Rising edge expects a synchronous hold, falling edge tolerates an asynchronous one
    s_next.hold_direct = HOLD_I;
    s_next.hold_meta = HOLD_I;
    s_next.hold_sync = s_reg.hold_meta;
    s_next.hold_out = s_reg.hold_input_edge_select ? s_reg.hold_sync : s_reg.hold_direct;
  end

  // Only the power-on reset reloads the registers, so manual reset and standby keep them
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_reg <= '0;
      s_reg.area_bus_width_config <= WIDTH_CFG_RESET;
      s_reg.area_idle_cycle_config <= IDLE_CFG_RESET;
      s_reg.hold_input_edge_select <= EDGE_SEL_RESET;
      s_reg.port_data <= PORT_DATA_RESET;
      s_reg.port_dir <= PORT_DIR_RESET;
      s_reg.pins_oe_n <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    for (int n = FIRST_WIDTH_AREA; n <= LAST_WIDTH_AREA; n++) begin
      AREA_WIDTH_CODE_O[2*(n-1) +: 2] = area_field(s_reg.area_bus_width_config, 3'(n));
    end
  end

  assign AREA_WIDTH_RESERVED_O = width_rsvd;
  assign UPPER_LANE_GPIO_SELECT_O = s_reg.area_bus_width_config[GPIO_SEL_BIT];
  assign UPPER_DATA_LANE_PINS_O = s_reg.pins_out;
  assign UPPER_DATA_LANE_PINS_OE_N_O = s_reg.pins_oe_n;
  assign BUS_UPPER_DATA_O = s_reg.bus_upper;
  assign HOLD_SAMPLED_O = s_reg.hold_out;
  assign HOLD_INPUT_EDGE_SELECT_O = s_reg.hold_input_edge_select;
  assign BUS_GRANT_O = gap_grant;
  assign IDLE_GAP_ACTIVE_O = gap_active;

endmodule

`default_nettype wire

// File: area_bus_width_idle_config_tb.sv
`default_nettype none

module area_bus_width_idle_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import area_cfg_pkg::*;
  logic CLK_I, RESET_I, MANUAL_RESET_I, STANDBY_I, S_AXI_AWVALID_I, S_AXI_WVALID_I;
  logic S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I, BUS_UPPER_DRIVE_I, HOLD_I;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic BUS_GRANT_O, IDLE_GAP_ACTIVE_O, UPPER_LANE_GPIO_SELECT_O, HOLD_SAMPLED_O;
  logic HOLD_INPUT_EDGE_SELECT_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [3:0] S_AXI_WSTRB_I;
  logic [5:0] AREA_WIDTH_RESERVED_O;
  logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I, BUS_UPPER_DATA_I, BUS_UPPER_DATA_O;
  logic [7:0] UPPER_DATA_LANE_PINS_I, UPPER_DATA_LANE_PINS_O, UPPER_DATA_LANE_PINS_OE_N_O;
  logic [11:0] AREA_WIDTH_CODE_O;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, d;
  bus_req_s BUS_REQ_I;
  logic [15:0] wm, im;
  logic em;
  int errors = 0, compares = 0, cyc = 0, prev_area, seed;
  logic prev_wr;

  area_bus_width_idle_config uut (.CLK_I, .RESET_I, .MANUAL_RESET_I, .STANDBY_I,
    .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_AWADDR_I, .S_AXI_AWPROT_I(3'h0),
    .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_BVALID_O,
    .S_AXI_BREADY_I, .S_AXI_BRESP_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_ARADDR_I,
    .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O, .S_AXI_RREADY_I, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
    .BUS_REQ_I, .BUS_GRANT_O, .IDLE_GAP_ACTIVE_O, .AREA_WIDTH_CODE_O, .AREA_WIDTH_RESERVED_O,
    .UPPER_LANE_GPIO_SELECT_O, .BUS_UPPER_DATA_I, .BUS_UPPER_DRIVE_I, .BUS_UPPER_DATA_O,
    .UPPER_DATA_LANE_PINS_I, .UPPER_DATA_LANE_PINS_O, .UPPER_DATA_LANE_PINS_OE_N_O,
    .HOLD_I, .HOLD_SAMPLED_O, .HOLD_INPUT_EDGE_SELECT_O);
  ext_dev_model dev (.clk_i(CLK_I), .reset_i(RESET_I), .out_i(UPPER_DATA_LANE_PINS_O),
    .oe_n_i(UPPER_DATA_LANE_PINS_OE_N_O), .pins_o(UPPER_DATA_LANE_PINS_I), .hold_o(HOLD_I));

  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  task automatic close_out();
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bus engine traffic on the lane keeps moving so the pin path is exercised whenever the lane belongs to the bus
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    BUS_UPPER_DATA_I <= 8'(cyc) ^ 8'h3c;
    BUS_UPPER_DRIVE_I <= cyc[2];
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] rsp_of(input logic [7:0] a);
    return (a > OFS_STATUS || a[1:0] != 2'h0) ? RESP_DECERR : RESP_OKAY;
  endfunction

  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] v,
                                      input logic [3:0] s);
    return {s[1] ? v[15:8] : o[15:8], s[0] ? v[7:0] : o[7:0]};
  endfunction

  task automatic cfg_chk();
    chk(32'(AREA_WIDTH_CODE_O), 32'(wm[13:2]));
    chk(32'(UPPER_LANE_GPIO_SELECT_O), 32'(wm[0]));
    chk(32'(HOLD_INPUT_EDGE_SELECT_O), 32'(em));
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, b;
    logic [1:0] rsp;
    b = 1'b0;
    rsp = 2'bxx;
    @(posedge CLK_I);
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_AWADDR_I <= a;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_WDATA_I <= v;
    S_AXI_WSTRB_I <= s;
    S_AXI_BREADY_I <= 1'b1;
    while (!b) begin
      @(negedge CLK_I);
      ta = S_AXI_AWVALID_I && S_AXI_AWREADY_O === 1'b1;
      tw = S_AXI_WVALID_I && S_AXI_WREADY_O === 1'b1;
      b = S_AXI_BVALID_O === 1'b1;
      rsp = S_AXI_BRESP_O;
      @(posedge CLK_I);
      if (ta) S_AXI_AWVALID_I <= 1'b0;
      if (tw) S_AXI_WVALID_I <= 1'b0;
      if (b) S_AXI_BREADY_I <= 1'b0;
    end
    chk(32'(rsp), 32'(rsp_of(a)));
    if (a == OFS_WIDTH_CFG) wm = mrg(wm, v, s) & 16'h3ffd;
    if (a == OFS_IDLE_CFG) im = mrg(im, v, s) & 16'h3fff;
    if (a == OFS_IDLE_CFG && s[1]) em = v[15];
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic ta, r;
    logic [31:0] dat;
    logic [1:0] rsp;
    r = 1'b0;
    @(posedge CLK_I);
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_ARADDR_I <= a;
    S_AXI_RREADY_I <= 1'b1;
    while (!r) begin
      @(negedge CLK_I);
      ta = S_AXI_ARVALID_I && S_AXI_ARREADY_O === 1'b1;
      r = S_AXI_RVALID_O === 1'b1;
      dat = r ? S_AXI_RDATA_O : 32'hx;
      rsp = S_AXI_RRESP_O;
      @(posedge CLK_I);
      if (ta) S_AXI_ARVALID_I <= 1'b0;
      if (r) S_AXI_RREADY_I <= 1'b0;
    end
    chk(dat, exp);
    chk(32'(rsp), 32'(rsp_of(a)));
  endtask

  // Entered on a rising edge; leaves the request standing so the next one follows at once
  task automatic bus_req(input logic [2:0] ar, input logic wr);
    int n, ex;
    n = 0;
    ex = 0;
    if (prev_area != 7 && (prev_area != ar || (!prev_wr && wr))) ex = im[2*prev_area +: 2];
    BUS_REQ_I <= '{valid: 1'b1, area: ar, write: wr};
    @(negedge CLK_I);
    while (BUS_GRANT_O !== 1'b1 && n < 10) begin
      n++;
      @(negedge CLK_I);
    end
    chk(32'(n), 32'(ex));
    prev_area = ar;
    prev_wr = wr;
    @(posedge CLK_I);
  endtask

  initial begin
    seed = 32'h0bc2;
    RESET_I = 1'b1;
    {MANUAL_RESET_I, STANDBY_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} = '0;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I, BUS_UPPER_DRIVE_I, BUS_UPPER_DATA_I} = '0;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, S_AXI_WSTRB_I, BUS_REQ_I} = '0;
    for (int k = 0; k < 2; k++) begin
      wm = 16'h3ffc;
      im = 16'h3fff;
      em = 1'b0;
      repeat (4) @(posedge CLK_I);
      RESET_I <= 1'b0;
      rd_chk(OFS_WIDTH_CFG, 32'h3ffc);
      rd_chk(OFS_IDLE_CFG, 32'h3fff);
      cfg_chk();
      if (k == 1) close_out();
      for (int i = 0; i < 10; i++) begin
        d = $random(seed);
        if (!d[31]) d = (d & 32'h1555) | ((~d & 32'h1554) << 1);
        else d = d & 32'hffffbfff;
        axi_wr(d[31] ? OFS_IDLE_CFG : OFS_WIDTH_CFG, d, d[31] ? 4'($random(seed)) : 4'hf);
        cfg_chk();
        rd_chk(d[31] ? OFS_IDLE_CFG : OFS_WIDTH_CFG, d[31] ? 32'(im) : 32'(wm));
      end
      axi_wr(8'h20, 32'hffffffff, 4'hf);
      rd_chk(8'h20, 32'h0);
      axi_wr(OFS_STATUS, 32'hffffffff, 4'hf);
      @(posedge CLK_I);
      MANUAL_RESET_I <= 1'b1;
      STANDBY_I <= 1'b1;
      repeat (5) @(posedge CLK_I);
      MANUAL_RESET_I <= 1'b0;
      STANDBY_I <= 1'b0;
      prev_area = 7;
      cfg_chk();
      rd_chk(OFS_WIDTH_CFG, 32'(wm));
      rd_chk(OFS_IDLE_CFG, 32'(im));
      for (int c = 0; c < 8; c++) begin
        axi_wr(OFS_WIDTH_CFG, 32'h2aa0 | 32'(c % 4) << 2 | 32'(c / 4), 4'h3);
        @(negedge CLK_I);
        chk(32'(AREA_WIDTH_RESERVED_O), 32'(c % 4 == 0 || c == 7));
        rd_chk(OFS_STATUS, 32'(c % 4 == 0 || c == 7) | 32'(c == 7) << STAT_CONFLICT_BIT |
          32'(em) << STAT_EDGE_BIT);
        cfg_chk();
      end
      axi_wr(OFS_WIDTH_CFG, 32'h2aa9, 4'h3);
      axi_wr(OFS_PORT_DATA, 32'ha5, 4'h1);
      axi_wr(OFS_PORT_DIR, 32'h0f, 4'h1);
      repeat (3) @(posedge CLK_I);
      chk(32'(UPPER_DATA_LANE_PINS_OE_N_O), 32'hf0);
      rd_chk(OFS_PORT_DATA, 32'h55);
      rd_chk(OFS_PORT_DIR, 32'h0f);
      for (int c = 0; c < 4; c++) begin
        axi_wr(OFS_IDLE_CFG, 32'h3f3f | 32'(c) << 6, 4'h3);
        bus_req(3'h3, 1'b0);
        bus_req(3'h3, 1'b1);
        bus_req(3'h3, 1'b1);
        bus_req(3'h2, 1'b0);
        bus_req(3'h3, 1'b0);
        BUS_REQ_I <= '0;
      end
      RESET_I <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// File: area_cfg_assertions.sv
`default_nettype none

module area_cfg_checker (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic STANDBY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_BVALID_O,
  input wire area_cfg_pkg::bus_req_s BUS_REQ_I,
  input wire logic BUS_GRANT_O,
  input wire logic IDLE_GAP_ACTIVE_O,
  input wire logic [11:0] AREA_WIDTH_CODE_O,
  input wire logic [5:0] AREA_WIDTH_RESERVED_O,
  input wire logic UPPER_LANE_GPIO_SELECT_O,
  input wire logic [7:0] BUS_UPPER_DATA_I,
  input wire logic BUS_UPPER_DRIVE_I,
  input wire logic [7:0] BUS_UPPER_DATA_O,
  input wire logic [7:0] UPPER_DATA_LANE_PINS_I,
  input wire logic [7:0] UPPER_DATA_LANE_PINS_O,
  input wire logic [7:0] UPPER_DATA_LANE_PINS_OE_N_O,
  input wire logic HOLD_I,
  input wire logic HOLD_SAMPLED_O,
  input wire logic HOLD_INPUT_EDGE_SELECT_O
);
  timeunit 1ns;
  timeprecision 1ns;
  import area_cfg_pkg::*;
  logic [5:0] rsvd_exp;
  logic rd_w;
  logic rd_i;
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      rsvd_exp[n] = AREA_WIDTH_CODE_O[2*n +: 2] == WIDTH_RSVD ||
        (UPPER_LANE_GPIO_SELECT_O && AREA_WIDTH_CODE_O[2*n +: 2] == WIDTH_32);
    end
  end
  assign rd_w = S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == OFS_WIDTH_CFG;
  assign rd_i = S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == OFS_IDLE_CFG;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  reset_load_a: assert property ($fell(RESET_I) |-> AREA_WIDTH_CODE_O == 12'hfff &&
    !UPPER_LANE_GPIO_SELECT_O && !HOLD_INPUT_EDGE_SELECT_O) else $error("reset values wrong");
  cfg_keep_a: assert property (!$rose(S_AXI_BVALID_O) |-> $stable(AREA_WIDTH_CODE_O) &&
    $stable(UPPER_LANE_GPIO_SELECT_O) && $stable(HOLD_INPUT_EDGE_SELECT_O))
    else $error("config changed without a write");
  rsvd_map_a: assert property (AREA_WIDTH_RESERVED_O == rsvd_exp)
    else $error("reserved width flags wrong");
  grant_cause_a: assert property (BUS_GRANT_O |-> BUS_REQ_I.valid && !STANDBY_I)
    else $error("grant without request or in standby");
  gap_bound_a: assert property ($rose(IDLE_GAP_ACTIVE_O) |-> ##[1:4] !IDLE_GAP_ACTIVE_O)
    else $error("idle gap too long");
  bus_pins_a: assert property (!UPPER_LANE_GPIO_SELECT_O ##1 !UPPER_LANE_GPIO_SELECT_O |->
    UPPER_DATA_LANE_PINS_OE_N_O == {8{!$past(BUS_UPPER_DRIVE_I)}} &&
    (!$past(BUS_UPPER_DRIVE_I) || UPPER_DATA_LANE_PINS_O == $past(BUS_UPPER_DATA_I)))
    else $error("bus lane pins wrong");
  port_lane_a: assert property (UPPER_LANE_GPIO_SELECT_O ##1 UPPER_LANE_GPIO_SELECT_O |->
    BUS_UPPER_DATA_O == 8'h00) else $error("bus sees port lane");
  width_read_a: assert property (rd_w |=> S_AXI_RVALID_O && S_AXI_RDATA_O ==
    {18'h0, $past(AREA_WIDTH_CODE_O), 1'b0, $past(UPPER_LANE_GPIO_SELECT_O)})
    else $error("width register read wrong");
  idle_read_a: assert property (rd_i |=> S_AXI_RVALID_O && S_AXI_RDATA_O[31:14] == 18'h0)
    else $error("idle register upper bits not zero");
  hold_rise_a: assert property (!HOLD_INPUT_EDGE_SELECT_O [*4] |->
    HOLD_SAMPLED_O == $past(HOLD_I, 2)) else $error("rising edge wait sampling wrong");
  hold_fall_a: assert property (HOLD_INPUT_EDGE_SELECT_O [*4] |->
    HOLD_SAMPLED_O == $past(HOLD_I, 3)) else $error("falling edge wait sampling wrong");
  bus_lane_in_a: assert property (!UPPER_LANE_GPIO_SELECT_O ##1 !UPPER_LANE_GPIO_SELECT_O |->
    BUS_UPPER_DATA_O == $past(UPPER_DATA_LANE_PINS_I)) else $error("bus lane input wrong");

  cover property (BUS_GRANT_O && $past(IDLE_GAP_ACTIVE_O));
  cover property ($rose(S_AXI_BVALID_O));
  cover property (UPPER_LANE_GPIO_SELECT_O && UPPER_DATA_LANE_PINS_OE_N_O == 8'h00);
endmodule

bind area_bus_width_idle_config area_cfg_checker chk_i (.CLK_I, .RESET_I, .STANDBY_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_ARADDR_I, .S_AXI_RVALID_O, .S_AXI_RDATA_O,
  .S_AXI_BVALID_O, .BUS_REQ_I, .BUS_GRANT_O, .IDLE_GAP_ACTIVE_O, .AREA_WIDTH_CODE_O,
  .AREA_WIDTH_RESERVED_O, .UPPER_LANE_GPIO_SELECT_O, .BUS_UPPER_DATA_I, .BUS_UPPER_DRIVE_I,
  .BUS_UPPER_DATA_O, .UPPER_DATA_LANE_PINS_I, .UPPER_DATA_LANE_PINS_O,
  .UPPER_DATA_LANE_PINS_OE_N_O, .HOLD_I, .HOLD_SAMPLED_O, .HOLD_INPUT_EDGE_SELECT_O);

`default_nettype wire

// File: area_cfg_pkg.sv
`default_nettype none

package area_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;

  // Register byte addresses on the AXI4-Lite port
  localparam logic [ADDR_W-1:0] OFS_WIDTH_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IDLE_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // Values loaded by the power-on reset
  localparam logic [15:0] WIDTH_CFG_RESET = 16'h3ffc;
  localparam logic [15:0] IDLE_CFG_RESET = 16'h3fff;
  localparam logic [PORT_W-1:0] PORT_DATA_RESET = 8'h00;
  localparam logic [PORT_W-1:0] PORT_DIR_RESET = 8'h00;
  localparam logic EDGE_SEL_RESET = 1'b0;

  // Bits that hold state; all others read as zero
  localparam logic [15:0] WIDTH_CFG_KEEP = 16'h3ffd;
  localparam logic [15:0] IDLE_CFG_KEEP = 16'h3fff;
  localparam int GPIO_SEL_BIT = 0;
  localparam int EDGE_SEL_BIT = 15;
  localparam int STAT_CONFLICT_BIT = 8;
  localparam int STAT_GAP_BIT = 9;
  localparam int STAT_EDGE_BIT = 10;

  localparam int FIRST_WIDTH_AREA = 1;
  localparam int LAST_WIDTH_AREA = 6;
  localparam logic [2:0] LAST_IDLE_AREA = 3'h6;

  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {GAP_IDLE = 1'b0, GAP_COUNT = 1'b1} gap_state_e;

  typedef struct packed {
    logic valid;
    logic [2:0] area;
    logic write;
  } bus_req_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } reg_wr_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } reg_rd_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic ok;
  } reg_rsp_s;

  // Two-bit field of area n at bits 2n+1:2n
  function automatic logic [1:0] area_field(input logic [15:0] v, input logic [2:0] n);
    return v[{n, 1'b0} +: 2];
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction

endpackage

`default_nettype wire

// File: axi_lite_reg_port.sv
`default_nettype none

module axi_lite_reg_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [area_cfg_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [area_cfg_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [area_cfg_pkg::ADDR_W-1:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [area_cfg_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output area_cfg_pkg::reg_wr_s wr_o,
  input wire logic wr_ok_i,
  output area_cfg_pkg::reg_rd_s rd_o,
  input wire area_cfg_pkg::reg_rsp_s rd_rsp_i
);
  import area_cfg_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [DATA_W-1:0] r_data;
    logic [1:0] r_resp;
  } port_s;

  port_s s_reg;
  port_s s_next;

  // Address and data are parked separately so either may arrive first
  always_comb begin
    s_next = s_reg;
    wr_o = '0;
    rd_o = '0;
    awready_o = !s_reg.aw_got && !s_reg.b_valid;
    wready_o = !s_reg.w_got && !s_reg.b_valid;
    arready_o = !s_reg.r_valid;
    if (awvalid_i && awready_o) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata_i;
      s_next.w_strb = wstrb_i;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      wr_o.en = 1'b1;
      wr_o.addr = s_reg.aw_addr;
      wr_o.data = s_reg.w_data;
      wr_o.strb = s_reg.w_strb;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = wr_ok_i ? RESP_OKAY : RESP_DECERR;
    end
    if (s_reg.b_valid && bready_i) begin
      s_next.b_valid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      rd_o.en = 1'b1;
      rd_o.addr = araddr_i;
      s_next.r_valid = 1'b1;
      s_next.r_data = rd_rsp_i.data;
      s_next.r_resp = rd_rsp_i.ok ? RESP_OKAY : RESP_DECERR;
    end
    if (s_reg.r_valid && rready_i) begin
      s_next.r_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bvalid_o = s_reg.b_valid;
  assign bresp_o = s_reg.b_resp;
  assign rvalid_o = s_reg.r_valid;
  assign rdata_o = s_reg.r_data;
  assign rresp_o = s_reg.r_resp;

endmodule

`default_nettype wire

// File: ext_dev_model.sv
`default_nettype none

module ext_dev_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  output logic [7:0] pins_o,
  output logic hold_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_reg;
  // Lines the device releases carry the far side's own byte, never a stale level
  assign pins_o = (out_i & ~oe_n_i) | (8'h5a & oe_n_i);
  // Wait moves only just after a rising edge, so rising-edge sampling stays safe
  always_ff @(posedge clk_i) begin
    if (reset_i) lfsr_reg <= 8'h01;
    else lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
  end
  assign hold_o = lfsr_reg[0];
endmodule

`default_nettype wire

// File: idle_gap_ctrl.sv
`default_nettype none

module idle_gap_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hold_i,
  input wire logic [15:0] idle_cfg_i,
  input wire area_cfg_pkg::bus_req_s req_i,
  output logic ready_o,
  output logic gap_active_o
);
  import area_cfg_pkg::*;

  typedef struct packed {
    gap_state_e state;
    logic [1:0] count;
    logic have_prev;
    logic [2:0] prev_area;
    logic prev_read;
  } gap_s;

  gap_s s_reg;
  gap_s s_next;
  logic [1:0] need;
  logic take;

  always_comb begin
    s_next = s_reg;
    need = 2'h0;
    take = 1'b0;
    // Area change, or read then write in one area, lets the last driver release the bus
    if (s_reg.have_prev && s_reg.prev_area <= LAST_IDLE_AREA &&
        (req_i.area != s_reg.prev_area || (s_reg.prev_read && req_i.write))) begin
      need = area_field(idle_cfg_i, s_reg.prev_area);
    end
    unique case (s_reg.state)
      GAP_IDLE: begin
        if (req_i.valid && !hold_i) begin
          if (need == 2'h0) begin
            take = 1'b1;
          end else begin
            // The cycle of detection is the first idle cycle
            s_next.count = need - 2'h1;
            s_next.state = GAP_COUNT;
          end
        end
      end
      GAP_COUNT: begin
        if (s_reg.count != 2'h0) begin
          s_next.count = s_reg.count - 2'h1;
        end else if (req_i.valid && !hold_i) begin
          take = 1'b1;
          s_next.state = GAP_IDLE;
        end
      end
    endcase
    if (take) begin
      s_next.have_prev = 1'b1;
      s_next.prev_area = req_i.area;
      s_next.prev_read = !req_i.write;
    end
    ready_o = take;
    gap_active_o = s_reg.state == GAP_COUNT;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

`default_nettype wire
